// file: core/hfgd_pkg.sv
`default_nettype none
package hfgd_pkg;
  // Frame length selects the number of 64-sample gain subframes
  typedef enum logic [1:0] {
    SHORT_HIGHBAND_FRAME  = 2'h0,
    MEDIUM_HIGHBAND_FRAME = 2'h1,
    LONG_HIGHBAND_FRAME   = 2'h2
  } hfgd_frame_kind_type;

  localparam logic [4:0] SUBFRAMES_SHORT  = 5'h04;
  localparam logic [4:0] SUBFRAMES_MEDIUM = 5'h08;
  localparam logic [4:0] SUBFRAMES_LONG   = 5'h10;
  localparam logic [5:0] SUBFRAME_LAST    = 6'h3F;

  // Gains in dB are signed Q8.8
  localparam logic signed [15:0] GAIN_MEM_RESET   = 16'sh0000;
  localparam logic signed [15:0] GAIN_FLOOR_DB    = 16'shEC00;
  localparam logic [8:0]         GAIN_DECAY       = 9'h0E6;
  localparam logic [15:0]        STEP_DB          = 16'h0300;
  localparam logic signed [15:0] MEDIUM_OFFSET_DB = 16'sh0480;
  localparam logic signed [15:0] LONG_OFFSET_DB   = 16'sh0A80;

  // dB to log2 factor and 2^f polynomial, all Q0.16
  localparam logic [15:0] DB_TO_LOG2 = 16'h2A85;
  localparam logic [15:0] POW2_C1    = 16'hA810;
  localparam logic [15:0] POW2_C2    = 16'h57F0;
  localparam int          LIN_FRAC   = 12;

  // Pulse threshold low-pass, Q1.15 coefficients
  localparam logic [15:0] THRES_POLE  = 16'h7D71;
  localparam logic [15:0] THRES_GAIN  = 16'h028F;
  localparam logic [17:0] THRES_RESET = 18'h00000;

  // Energy smoothing, energy in Q.30 and 1.414 factors in Q1.15
  localparam logic [39:0] ENERGY_FLOOR = 40'h000001A36E;
  localparam logic [39:0] SMOOTH_RESET = 40'h0000000000;
  localparam logic [15:0] SQRT2_UP     = 16'hB505;
  localparam logic [15:0] SQRT2_DOWN   = 16'h5A86;
  localparam int          RATIO_FRAC   = 14;
  localparam logic [3:0]  DIV_FIRST    = 4'hE;
  localparam logic [16:0] RATIO_ONE    = 17'h04000;

  // Frame command from the demultiplexer
  typedef struct packed {
    hfgd_frame_kind_type kind;
    logic [6:0]          first_idx;
    logic [3:0]          loss;
    logic [47:0]         second_idx;
  } hfgd_frame_cmd_type;

  // Low-band excitation sample with its interpolated estimated gain
  typedef struct packed {
    logic signed [15:0] sample;
    logic signed [15:0] est_gain_db;
  } hfgd_exc_type;

  // Codebook load word: four Q8.8 gains, gain 0 in the low bits
  typedef struct packed {
    logic [6:0]  addr;
    logic [63:0] gains;
  } hfgd_cb_write_type;
endpackage
`default_nettype wire

// file: core/hfgd_top.sv
// Overview of operation
// - 4, 8 or 16 subframes per frame
// - Gain is estimate plus both stage corrections
// - 7-bit index reads four-gain codebook, flag zero
// - Good frame: codebook vector plus mean offset
// - Lost frame: decay memory, repeat, store average
// - Expand first-stage gains by one, two, four
// - Short frames have zero second-stage correction
// - Medium: three times index minus 4.5 dB
// - Long: three times index minus 10.5 dB
// - Convert dB gain to linear factor
// - Clip pulses above twice threshold, keep sign
// - Threshold is low-passed magnitude, reset zero
// - Excess halves into threshold, shrinks sample
// - Subframe energy is floor plus squares
// - Pull smoothing threshold within 1.414 of energy
// - Scale subframe by root of ratio
// - Shape excitation by one gain per sample
`default_nettype none
module hfgd_top
  import hfgd_pkg::*;
#(
  parameter logic signed [15:0] GAIN_MEAN_OFFSET = 16'sh0000
) (
  // Clock, reset, enable
  input  wire logic               clk,
  input  wire logic               rst_n,
  input  wire logic               ce,
  // Codebook load
  input  wire logic               cb_wr_en,
  input  wire hfgd_cb_write_type  cb_wr,
  // Frame command
  input  wire logic               cmd_valid,
  output logic                    cmd_ready,
  input  wire hfgd_frame_cmd_type cmd,
  // Low-band excitation in
  input  wire logic               exc_valid,
  output logic                    exc_ready,
  input  wire hfgd_exc_type       exc,
  // High-band excitation out
  output logic                    hbx_valid,
  input  wire logic               hbx_ready,
  output logic signed [15:0]      highband_excitation,
  // High-band synthesis in
  input  wire logic               syn_valid,
  output logic                    syn_ready,
  input  wire logic signed [15:0] highband_synthesis,
  // Smoothed synthesis out
  output logic                    smo_valid,
  input  wire logic               smo_ready,
  output logic signed [15:0]      smoothed_synthesis,
  // Status
  output logic                    frame_busy
);
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_LOAD = 3'b010,
    ST_RUN  = 3'b100
  } hfgd_dec_state_type;
  typedef enum logic [3:0] {
    SM_FILL = 4'b0001,
    SM_UPD  = 4'b0010,
    SM_DIV  = 4'b0100,
    SM_OUT  = 4'b1000
  } hfgd_smo_state_type;
  // Saturate a wide signed value to a 16-bit sample
  function automatic logic signed [15:0] sat16(input logic signed [39:0] v);
    return (v > 40'sh0000007FFF) ? 16'sh7FFF :
           (v < -40'sh0000008000) ? -16'sh8000 : v[15:0];
  endfunction
  function automatic logic [4:0] subframe_total(input hfgd_frame_kind_type k);
    unique case (k)
      SHORT_HIGHBAND_FRAME:  return SUBFRAMES_SHORT;
      MEDIUM_HIGHBAND_FRAME: return SUBFRAMES_MEDIUM;
      default:               return SUBFRAMES_LONG;
    endcase
  endfunction
  // 10^(g/20) as 2^(g*log2(10)/20); fraction by a quadratic, Q4.12 result
  function automatic logic [15:0] db_to_lin(input logic signed [15:0] g_db);
    logic signed [32:0] l2;
    logic signed [8:0]  ip;
    logic [15:0]        f;
    logic [31:0]        t1;
    logic [16:0]        inner;
    logic [32:0]        t2;
    logic [16:0]        mant;
    logic [33:0]        sh;
    l2    = g_db * $signed({1'b0, DB_TO_LOG2});
    ip    = l2[32:24];
    f     = l2[23:8];
    t1    = POW2_C2 * f;
    inner = {1'b0, POW2_C1} + {1'b0, t1[31:16]};
    t2    = f * inner;
    mant  = 17'h10000 + t2[32:16];
    sh    = {17'h00000, mant} << 5'(ip + 9'sd13);
    return (ip > 9'sd3) ? 16'hFFFF : (ip < -9'sd13) ? 16'h0000 : sh[32:17];
  endfunction
  // Reset release through two flip-flops
  logic [1:0] rst_sync_reg;
  logic       rst_int_n;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n)
      rst_sync_reg <= 2'b00;
    else
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
  end
  assign rst_int_n = rst_sync_reg[1];
  // First-stage codebook, filled by the host before use
  logic [63:0] cb_mem [128];
  always_ff @(posedge clk) begin
    if (ce && cb_wr_en)
      cb_mem[cb_wr.addr] <= cb_wr.gains;
  end
  hfgd_dec_state_type       dec_state_reg;
  hfgd_frame_cmd_type       cmd_reg;
  logic [63:0]              cb_rd_reg;
  logic signed [15:0]       g1_reg [4];
  logic signed [15:0]       g1_next [4];
  logic signed [15:0]       gmem_reg;
  logic signed [15:0]       gmem_next;
  logic [3:0]               sf_reg;
  logic [5:0]               smp_reg;
  logic                     exc_take;
  logic                     last_smp;
  assign cmd_ready  = ce && dec_state_reg == ST_IDLE;
  assign frame_busy = ~dec_state_reg[0];
  assign exc_take   = exc_valid && exc_ready;
  assign last_smp   = smp_reg == SUBFRAME_LAST
                      && {1'b0, sf_reg} == subframe_total(cmd_reg.kind) - 5'h01;
  // First-stage gains and the predictor memory for the next frame
  always_comb begin
    logic signed [16:0] lifted;
    logic signed [25:0] scaled;
    logic signed [17:0] sum;
    lifted = 17'(gmem_reg) - 17'(GAIN_FLOOR_DB);
    scaled = lifted * $signed({1'b0, GAIN_DECAY});
    sum    = 18'sh00000;
    for (int k = 0; k < 4; k++) begin
      sum = sum + 18'($signed(cb_rd_reg[16*k +: 16]));
    end
    if (cmd_reg.loss[0]) begin
      gmem_next = 16'(scaled >>> 8) + GAIN_FLOOR_DB;
      for (int k = 0; k < 4; k++) begin
        g1_next[k] = gmem_next + GAIN_MEAN_OFFSET;
      end
    end else begin
      gmem_next = 16'(sum >>> 2);
      for (int k = 0; k < 4; k++) begin
        g1_next[k] = $signed(cb_rd_reg[16*k +: 16]) + GAIN_MEAN_OFFSET;
      end
    end
  end
  // Frame sequencing: take command, read codebook, run the subframes
  always_ff @(posedge clk or negedge rst_int_n) begin
    if (!rst_int_n) begin
      dec_state_reg <= ST_IDLE;
      cmd_reg       <= '0;
      cb_rd_reg     <= 64'h0000000000000000;
      gmem_reg      <= GAIN_MEM_RESET;
      sf_reg        <= 4'h0;
      smp_reg       <= 6'h00;
      g1_reg        <= '{default: 16'sh0000};
    end else if (ce) begin
      unique case (dec_state_reg)
        ST_IDLE: begin
          if (cmd_valid) begin
            cmd_reg       <= cmd;
            cb_rd_reg     <= cb_mem[cmd.first_idx];
            sf_reg        <= 4'h0;
            smp_reg       <= 6'h00;
            dec_state_reg <= ST_LOAD;
          end
        end
        ST_LOAD: begin
          gmem_reg      <= gmem_next;
          g1_reg        <= g1_next;
          dec_state_reg <= ST_RUN;
        end
        ST_RUN: begin
          if (exc_take) begin
            smp_reg <= smp_reg + 6'h01;
            if (smp_reg == SUBFRAME_LAST)
              sf_reg <= sf_reg + 4'h1;
            if (last_smp)
              dec_state_reg <= ST_IDLE;
          end
        end
      endcase
    end
  end
  // Per-sample gain in dB and the shaped, pulse-limited sample
  logic signed [15:0] g1_sel;
  logic signed [15:0] c2_db;
  logic signed [15:0] gain_db;
  logic [15:0]        gain_lin;
  logic signed [15:0] shaped;
  logic [16:0]        mag;
  logic [17:0]        thres_reg;
  logic [17:0]        thres_f;
  logic [17:0]        thres_next;
  logic [18:0]        bound;
  logic [16:0]        delta;
  logic signed [15:0] reduced;
  always_comb begin
    logic [2:0]         idx2;
    logic signed [32:0] prod;
    logic [33:0]        filt;
    unique case (cmd_reg.kind)
      SHORT_HIGHBAND_FRAME:  g1_sel = g1_reg[sf_reg[1:0]];
      MEDIUM_HIGHBAND_FRAME: g1_sel = g1_reg[sf_reg[2:1]];
      default:               g1_sel = g1_reg[sf_reg[3:2]];
    endcase
    idx2 = cmd_reg.second_idx[3*sf_reg +: 3];
    if (cmd_reg.kind == SHORT_HIGHBAND_FRAME || cmd_reg.loss[0])
      c2_db = 16'sh0000;
    else if (cmd_reg.kind == MEDIUM_HIGHBAND_FRAME)
      c2_db = $signed(16'({1'b0, idx2[1:0]} * STEP_DB)) - MEDIUM_OFFSET_DB;
    else
      c2_db = $signed(16'(idx2 * STEP_DB)) - LONG_OFFSET_DB;
    gain_db  = exc.est_gain_db + g1_sel + c2_db;
    gain_lin = db_to_lin(gain_db);
    prod     = exc.sample * $signed({1'b0, gain_lin});
    shaped   = sat16(40'(prod >>> LIN_FRAC));
    mag      = shaped[15] ? 17'(-$signed({shaped[15], shaped})) : {1'b0, shaped};
    filt     = 34'(thres_reg * THRES_POLE) + 34'(mag * THRES_GAIN);
    thres_f  = 18'((filt + 34'h000004000) >> 15);
    bound    = {thres_f, 1'b0};
    delta    = ({2'b00, mag} > bound) ? 17'({2'b00, mag} - bound) : 17'h00000;
    thres_next = thres_f + 18'(delta >> 1);
    reduced  = 16'(shaped[15] ? shaped + $signed(delta) : shaped - $signed(delta));
  end
  // Excitation waits for both the decoded gains and a free output slot
  assign exc_ready = ce && dec_state_reg == ST_RUN && (!hbx_valid || hbx_ready);
  // Pulse threshold, rounded since a floor would bias the leaky sum low
  always_ff @(posedge clk or negedge rst_int_n) begin
    if (!rst_int_n)
      thres_reg <= THRES_RESET;
    else if (ce && exc_take)
      thres_reg <= thres_next;
  end

  // High-band excitation output register
  always_ff @(posedge clk or negedge rst_int_n) begin
    if (!rst_int_n) begin
      hbx_valid           <= 1'b0;
      highband_excitation <= 16'sh0000;
    end else if (ce) begin
      if (exc_take) begin
        hbx_valid           <= 1'b1;
        highband_excitation <= reduced;
      end else if (hbx_ready) begin
        hbx_valid <= 1'b0;
      end
    end
  end

  // Energy smoothing keeps a whole subframe, since its scale needs all 64
  hfgd_smo_state_type smo_state_reg;
  logic signed [15:0] syn_buf [64];
  logic [5:0]         fill_reg;
  logic [5:0]         out_reg;
  logic [39:0]        energy_reg;
  logic [39:0]        smooth_reg;
  logic [39:0]        smooth_next;
  logic [55:0]        rem_reg;
  logic [55:0]        trial;
  logic [3:0]         step_reg;
  logic [15:0]        ratio_reg;
  logic [15:0]        scale;
  logic signed [15:0] smo_data;

  assign syn_ready = ce && smo_state_reg == SM_FILL;

  always_comb begin
    logic [55:0]        up;
    logic [55:0]        down;
    logic signed [16:0] dev;
    logic [33:0]        dev_sq;
    logic [16:0]        half;
    logic signed [32:0] prod;
    up   = 56'(energy_reg * SQRT2_UP) >> 15;
    down = 56'(energy_reg * SQRT2_DOWN) >> 15;
    if (energy_reg < smooth_reg)
      smooth_next = (up[39:0] < smooth_reg) ? up[39:0] : smooth_reg;
    else
      smooth_next = (down[39:0] > smooth_reg) ? down[39:0] : smooth_reg;
    trial  = {16'h0000, energy_reg} << step_reg;
    // Root of a ratio near one: second-order series, error under 0.3 %
    dev    = $signed({1'b0, ratio_reg}) - $signed(RATIO_ONE);
    dev_sq = 34'(dev * dev);
    half   = 17'(({1'b0, ratio_reg} + RATIO_ONE) >> 1);
    scale  = 16'(half - 17'(dev_sq >> (RATIO_FRAC + 3)));
    prod   = syn_buf[out_reg] * $signed({1'b0, scale});
    smo_data = sat16(40'(prod >>> RATIO_FRAC));
  end

  // Collect, update threshold, divide, then emit the scaled subframe
  always_ff @(posedge clk or negedge rst_int_n) begin
    if (!rst_int_n) begin
      smo_state_reg <= SM_FILL;
      fill_reg      <= 6'h00;
      out_reg       <= 6'h00;
      energy_reg    <= ENERGY_FLOOR;
      smooth_reg    <= SMOOTH_RESET;
      rem_reg       <= 56'h0;
      step_reg      <= DIV_FIRST;
      ratio_reg     <= 16'h0000;
    end else if (ce) begin
      unique case (smo_state_reg)
        SM_FILL: begin
          if (syn_valid) begin
            syn_buf[fill_reg] <= highband_synthesis;
            energy_reg <= energy_reg + 40'(highband_synthesis * highband_synthesis);
            fill_reg   <= fill_reg + 6'h01;
            if (fill_reg == SUBFRAME_LAST)
              smo_state_reg <= SM_UPD;
          end
        end
        SM_UPD: begin
          smooth_reg    <= smooth_next;
          rem_reg       <= {2'b00, smooth_next, 14'h0000};
          step_reg      <= DIV_FIRST;
          ratio_reg     <= 16'h0000;
          smo_state_reg <= SM_DIV;
        end
        SM_DIV: begin
          if (rem_reg >= trial) begin
            rem_reg              <= rem_reg - trial;
            ratio_reg[step_reg]  <= 1'b1;
          end
          step_reg <= step_reg - 4'h1;
          if (step_reg == 4'h0) begin
            out_reg       <= 6'h00;
            smo_state_reg <= SM_OUT;
          end
        end
        SM_OUT: begin
          if (!smo_valid || smo_ready) begin
            out_reg <= out_reg + 6'h01;
            if (out_reg == SUBFRAME_LAST) begin
              energy_reg    <= ENERGY_FLOOR;
              smo_state_reg <= SM_FILL;
            end
          end
        end
      endcase
    end
  end

  // Smoothed output register
  always_ff @(posedge clk or negedge rst_int_n) begin
    if (!rst_int_n) begin
      smo_valid          <= 1'b0;
      smoothed_synthesis <= 16'sh0000;
    end else if (ce) begin
      if (smo_state_reg == SM_OUT && (!smo_valid || smo_ready)) begin
        smo_valid          <= 1'b1;
        smoothed_synthesis <= smo_data;
      end else if (smo_ready) begin
        smo_valid <= 1'b0;
      end
    end
  end

endmodule
`default_nettype wire

// file: test/hfgd_top_sva.sv
`default_nettype none
module hfgd_top_sva
  import hfgd_pkg::*;
(
  // Clock and reset
  input wire logic               clk,
  input wire logic               rst_n,
  input wire logic               ce,
  // Command and excitation
  input wire logic               cmd_valid,
  input wire logic               cmd_ready,
  input wire hfgd_frame_cmd_type cmd,
  input wire logic               exc_valid,
  input wire logic               exc_ready,
  input wire logic               hbx_valid,
  input wire logic               hbx_ready,
  input wire logic signed [15:0] highband_excitation,
  // Smoothing and status
  input wire logic               syn_valid,
  input wire logic               syn_ready,
  input wire logic               smo_valid,
  input wire logic               smo_ready,
  input wire logic signed [15:0] smoothed_synthesis,
  input wire logic               frame_busy
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  logic [10:0] take_cnt_reg;
  logic [10:0] frame_len_reg;
  logic [5:0]  syn_cnt_reg;

  // Samples taken since the last command, and how many that command owes
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      take_cnt_reg  <= 11'h000;
      frame_len_reg <= 11'h000;
    end else if (cmd_valid && cmd_ready) begin
      take_cnt_reg  <= 11'h000;
      frame_len_reg <= (cmd.kind == SHORT_HIGHBAND_FRAME) ? 11'h100 :
                       (cmd.kind == MEDIUM_HIGHBAND_FRAME) ? 11'h200 : 11'h400;
    end else if (exc_valid && exc_ready) begin
      take_cnt_reg <= take_cnt_reg + 11'h001;
    end
  end

  // Position inside the 64-sample smoothing subframe
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      syn_cnt_reg <= 6'h00;
    end else if (syn_valid && syn_ready) begin
      syn_cnt_reg <= syn_cnt_reg + 6'h01;
    end
  end

  sequence s_last_syn;
    syn_valid && syn_ready && syn_cnt_reg == 6'h3F;
  endsequence
  sequence s_busy_start;
    frame_busy ##1 frame_busy;
  endsequence

  a_busy_on_accept: assert property (cmd_valid && cmd_ready |=> s_busy_start)
    else $error("frame_busy did not follow an accepted command");
  a_cmd_busy_refused: assert property (frame_busy |-> !cmd_ready)
    else $error("command offered ready while busy");
  a_frame_length: assert property ($fell(frame_busy) |-> take_cnt_reg == frame_len_reg)
    else $error("frame ended after wrong sample count");
  a_exc_idle_refused: assert property (!frame_busy |-> !exc_ready)
    else $error("excitation ready outside a frame");
  a_hbx_after_take: assert property (exc_valid && exc_ready |=> hbx_valid)
    else $error("no shaped sample after a take");
  a_hbx_held: assert property (hbx_valid && !hbx_ready |=>
                               hbx_valid && $stable(highband_excitation))
    else $error("shaped sample changed while stalled");
  a_exc_stall: assert property (hbx_valid && !hbx_ready |-> !exc_ready)
    else $error("excitation taken while output stalled");
  a_smo_latency: assert property (s_last_syn |-> ##18 smo_valid)
    else $error("smoothed output late");
  a_syn_refused: assert property (s_last_syn |=> (!syn_ready) [*8])
    else $error("synthesis taken during update");
  a_smo_held: assert property (smo_valid && !smo_ready |=>
                               smo_valid && $stable(smoothed_synthesis))
    else $error("smoothed sample changed while stalled");
  a_ce_freeze: assert property (!ce |-> !cmd_ready && !exc_ready && !syn_ready)
    else $error("ready high with clock enable low");
endmodule

bind hfgd_top hfgd_top_sva u_sva (
  .clk(clk), .rst_n(rst_n), .ce(ce), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
  .cmd(cmd), .exc_valid(exc_valid), .exc_ready(exc_ready), .hbx_valid(hbx_valid),
  .hbx_ready(hbx_ready), .highband_excitation(highband_excitation),
  .syn_valid(syn_valid), .syn_ready(syn_ready), .smo_valid(smo_valid),
  .smo_ready(smo_ready), .smoothed_synthesis(smoothed_synthesis),
  .frame_busy(frame_busy)
);
`default_nettype wire

// file: test/hfgd_upstream_model.sv
`default_nettype none
module hfgd_upstream_model
  import hfgd_pkg::*;
(
  // Clock
  input  wire logic              clk,
  // Codebook load
  output var logic               cb_wr_en,
  output var hfgd_cb_write_type  cb_wr,
  // Frame command
  output var logic               cmd_valid,
  input  wire logic              cmd_ready,
  output var hfgd_frame_cmd_type cmd,
  // Excitation stream
  output var logic               exc_valid,
  input  wire logic              exc_ready,
  output var hfgd_exc_type       exc
);
  timeunit 1ns;
  timeprecision 100ps;

  // Quiet bus at start
  initial begin
    cb_wr_en  = 1'b0;
    cb_wr     = '0;
    cmd_valid = 1'b0;
    cmd       = '0;
    exc_valid = 1'b0;
    exc       = '0;
  end

  // One word per cycle; the codebook has no reset so it goes first
  task automatic load_codebook(input logic [63:0] words [128]);
    for (int a = 0; a < 128; a++) begin
      cb_wr_en = 1'b1;
      cb_wr    = {7'(a), words[a]};
      @(posedge clk);
      #1;
    end
    cb_wr_en = 1'b0;
    cb_wr    = ~cb_wr;
  endtask

  // Flags beyond what the frame length carries stay clear
  task automatic send_cmd(input hfgd_frame_cmd_type c);
    c.loss    = c.loss & ((c.kind == SHORT_HIGHBAND_FRAME) ? 4'h1 :
                (c.kind == MEDIUM_HIGHBAND_FRAME) ? 4'h3 : 4'hF);
    cmd_valid = 1'b1;
    cmd       = c;
    do @(negedge clk); while (!cmd_ready);
    @(posedge clk);
    #1;
    cmd_valid = 1'b0;
    cmd       = ~c;
  endtask

  // Held until taken; sometimes idles a cycle so the design sees gaps
  task automatic send_exc(input hfgd_exc_type e);
    exc_valid = 1'b1;
    exc       = e;
    do @(negedge clk); while (!exc_ready);
    @(posedge clk);
    #1;
    if ($urandom_range(0, 3) == 0) begin
      exc_valid = 1'b0;
      exc       = ~e;
      @(posedge clk);
      #1;
    end
  endtask

  task automatic end_exc();
    if (exc_valid) begin
      exc_valid = 1'b0;
      exc       = ~exc;
    end
  endtask
endmodule
`default_nettype wire

// file: test/tb.sv
`default_nettype none
module tb
  import hfgd_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic signed [15:0] MEAN_Q = 16'sh0100;
  localparam int                 LIMIT  = 40000;
  logic               clk, rst_n, ce, cb_wr_en, cmd_valid, cmd_ready, exc_valid;
  logic               exc_ready, hbx_valid, hbx_ready, syn_valid, syn_ready;
  logic               smo_valid, smo_ready, frame_busy;
  hfgd_cb_write_type  cb_wr;
  hfgd_frame_cmd_type cmd;
  hfgd_exc_type       exc;
  logic signed [15:0] highband_excitation, highband_synthesis, smoothed_synthesis;
  logic [63:0]        cb [128];
  real                exp_hbx [$], exp_smo [$];
  real                mem = 0.0, thr = 0.0, t_sm = 0.0;
  int                 mismatches = 0, comparisons = 0, cycles = 0;

  hfgd_top #(.GAIN_MEAN_OFFSET(MEAN_Q)) dut (
    .clk(clk), .rst_n(rst_n), .ce(ce), .cb_wr_en(cb_wr_en), .cb_wr(cb_wr),
    .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd(cmd), .exc_valid(exc_valid),
    .exc_ready(exc_ready), .exc(exc), .hbx_valid(hbx_valid), .hbx_ready(hbx_ready),
    .highband_excitation(highband_excitation), .syn_valid(syn_valid),
    .syn_ready(syn_ready), .highband_synthesis(highband_synthesis),
    .smo_valid(smo_valid), .smo_ready(smo_ready),
    .smoothed_synthesis(smoothed_synthesis), .frame_busy(frame_busy));
  hfgd_upstream_model up (
    .clk(clk), .cb_wr_en(cb_wr_en), .cb_wr(cb_wr), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .cmd(cmd), .exc_valid(exc_valid), .exc_ready(exc_ready),
    .exc(exc));

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic check_bit(input logic got, input logic want, input string what);
    comparisons++;
    if (got !== want) begin
      mismatches++;
      $display("ERROR t=%0t %s", $time, what);
    end
  endtask

  // Fixed-point paths are approximate, so allow 2 percent plus 16 LSB
  task automatic check_near(input logic signed [15:0] got, input real want, input string what);
    real d, tol;
    d = $itor(got) - want;
    tol = 0.02 * ((want < 0.0) ? -want : want) + 16.0;
    comparisons++;
    if ((^got === 1'bx) || d * d > tol * tol) begin
      mismatches++;
      $display("ERROR t=%0t %s got %0d want %0.1f", $time, what, got, want);
    end
  endtask

  function automatic real c2(hfgd_frame_kind_type k, logic [2:0] ix, logic lost);
    if (lost || k == SHORT_HIGHBAND_FRAME) return 0.0;
    if (k == MEDIUM_HIGHBAND_FRAME) return 3.0 * ix[1:0] - 4.5;
    return 3.0 * ix - 10.5;
  endfunction

  // One frame: gains from the rules, pulse limiter run on every sample
  task automatic run_frame(input hfgd_frame_kind_type k, input logic [6:0] idx, input logic lost);
    hfgd_frame_cmd_type c;
    hfgd_exc_type       e;
    real                g [4];
    real                lin, r, d, mean;
    int                 nb;
    nb = (k == SHORT_HIGHBAND_FRAME) ? 4 : (k == MEDIUM_HIGHBAND_FRAME) ? 8 : 16;
    mean = $itor(MEAN_Q) / 256.0;
    c = {k, idx, 3'($urandom), lost, 32'($urandom), 16'($urandom)};
    if (lost) mem = 0.9 * (mem + 20.0) - 20.0;
    for (int j = 0; j < 4; j++)
      g[j] = lost ? mem + mean : $itor($signed(cb[idx][16*j+:16])) / 256.0 + mean;
    mem = (g[0] + g[1] + g[2] + g[3]) / 4.0 - mean;
    up.send_cmd(c);
    for (int i = 0; i < nb; i++) begin
      e.est_gain_db = 16'(int'($urandom_range(0, 1536)) - 768);
      lin = 10.0 ** (($itor(e.est_gain_db) / 256.0 + g[i / (nb / 4)]
            + c2(k, c.second_idx[3*i+:3], lost)) / 20.0);
      for (int n = 0; n < 64; n++) begin
        e.sample = 16'(int'($urandom_range(0, 2000)) - 1000);
        if (n % 16 == 5) e.sample = (n > 31) ? 16'sh0BB8 : -16'sh0BB8;
        r = $itor(e.sample) * lin;
        thr = 0.98 * thr + 0.02 * (r < 0 ? -r : r);
        d = (r < 0 ? -r : r) - 2.0 * thr;
        if (d < 0.0) d = 0.0;
        thr = thr + 0.5 * d;
        exp_hbx.push_back(r >= 0.0 ? r - d : r + d);
        up.send_exc(e);
      end
    end
    up.end_exc();
    check_bit(frame_busy, 1'b0, "busy after last sample");
  endtask

  // One smoothing subframe of random samples within +-amp
  task automatic run_smooth(input int amp);
    logic signed [15:0] s [64];
    real                en;
    en = 0.0001;
    for (int n = 0; n < 64; n++) begin
      s[n] = 16'(int'($urandom_range(0, 2 * amp)) - amp);
      en = en + ($itor(s[n]) / 32768.0) ** 2;
    end
    if (en < t_sm) t_sm = (en * 1.414 < t_sm) ? en * 1.414 : t_sm;
    else t_sm = (en / 1.414 > t_sm) ? en / 1.414 : t_sm;
    for (int n = 0; n < 64; n++) exp_smo.push_back($itor(s[n]) * $sqrt(t_sm / en));
    for (int n = 0; n < 64; n++) begin
      syn_valid = 1'b1;
      highband_synthesis = s[n];
      do @(negedge clk); while (!syn_ready);
      @(posedge clk);
      #1;
    end
    syn_valid = 1'b0;
    highband_synthesis = ~s[63];
    @(posedge clk);
    #1;
  endtask

  // 250 MHz clock
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // Random output stalls and the run limit
  initial begin
    forever begin
      @(posedge clk);
      #1;
      hbx_ready = ($urandom_range(0, 3) != 0);
      smo_ready = ($urandom_range(0, 3) != 0);
      cycles++;
      if (cycles > LIMIT) begin
        mismatches++;
        give_verdict();
      end
    end
  end

  // Score each output sample as it is taken
  always @(negedge clk) begin
    if (rst_n && hbx_valid === 1'b1 && hbx_ready === 1'b1) begin
      check_bit(exp_hbx.size() != 0, 1'b1, "extra shaped sample");
      if (exp_hbx.size() != 0)
        check_near(highband_excitation, exp_hbx.pop_front(), "shaped");
    end
    if (rst_n && smo_valid === 1'b1 && smo_ready === 1'b1) begin
      check_bit(exp_smo.size() != 0, 1'b1, "extra smoothed sample");
      if (exp_smo.size() != 0)
        check_near(smoothed_synthesis, exp_smo.pop_front(), "smoothed");
    end
  end

  initial begin
    void'($urandom(32'h0C57705A));
    rst_n = 1'b0;
    ce = 1'b1;
    hbx_ready = 1'b0;
    smo_ready = 1'b0;
    syn_valid = 1'b0;
    highband_synthesis = 16'sh0000;
    repeat (12) @(posedge clk);
    #1 rst_n = 1'b1;
    repeat (3) @(posedge clk);
    #1;
    check_bit(exc_ready | hbx_valid | smo_valid | frame_busy, 1'b0, "idle after reset");
    check_bit(cmd_ready, 1'b1, "command ready after reset");
    ce = 1'b0;
    @(negedge clk);
    check_bit(cmd_ready | syn_ready, 1'b0, "ready with enable low");
    @(posedge clk);
    #1 ce = 1'b1;
    foreach (cb[a]) for (int j = 0; j < 4; j++)
      cb[a][16*j+:16] = 16'(int'($urandom_range(0, 2048)) - 1024);
    up.load_codebook(cb);
    run_frame(SHORT_HIGHBAND_FRAME, 7'h00, 1'b0);
    run_frame(MEDIUM_HIGHBAND_FRAME, 7'h7F, 1'b0);
    run_frame(LONG_HIGHBAND_FRAME, 7'($urandom), 1'b0);
    run_frame(MEDIUM_HIGHBAND_FRAME, 7'($urandom), 1'b1);
    run_frame(LONG_HIGHBAND_FRAME, 7'($urandom), 1'b1);
    run_frame(SHORT_HIGHBAND_FRAME, 7'($urandom), 1'b1);
    run_frame(SHORT_HIGHBAND_FRAME, 7'($urandom), 1'b0);
    run_smooth(3000);
    run_smooth(3000);
    run_smooth(300);
    run_smooth(9000);
    for (int w = 0; w < 3000 && exp_hbx.size() + exp_smo.size() != 0; w++) @(posedge clk);
    check_bit(exp_hbx.size() + exp_smo.size() == 0, 1'b1, "outputs missing");
    give_verdict();
  end
endmodule
`default_nettype wire
